// ===== rtl/spio_pkg.sv
// Package for the shared parallel I/O port: widths, offsets, reset values, carriers
package spio_pkg;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned ADDR_W = 4;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] OFF_DIRECTION = 4'h0;
  localparam logic [3:0] OFF_LEVEL = 4'h2;
  localparam logic [3:0] OFF_LATCH = 4'h4;
  localparam logic [3:0] OFF_PERIPH_EN = 4'h6;
  localparam logic [3:0] OFF_PERIPH_OUT = 4'h8;
  // Reset values
  localparam logic [15:0] DIR_RESET = 16'hffff;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] PEN_RESET = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // Direction encoding: one makes the pin an input
  localparam logic DIR_INPUT = 1'b1;
  // Per-pin peripheral output signals
  typedef struct packed {
    logic [15:0] drive;
    logic [15:0] data;
  } spio_periph_t;
  // Pad-side output pair
  typedef struct packed {
    logic [15:0] oe;
    logic [15:0] data;
  } spio_pad_t;
endpackage : spio_pkg

// ===== rtl/spio_port.sv
// Shared parallel I/O port: direction, output latch, pin level read and pad muxes
// Notes on behaviour
// - Direction bit one makes the pin an input, zero an output.
// - Every reset sets all direction bits, so all pins start as inputs.
// - Latch register reads the stored latch; writes update the latch.
// - Pin-level register reads pin states; writes go to the latch.
// - Latch drives each port-owned pin configured as output.
// - Actively driving enabled peripheral disables port driver; pin stays readable.
// - Enabled but idle peripheral leaves the pin to the port.
// - Data and enable muxes per pin, peripheral has priority.
// - Unimplemented bits read zero in latch, direction and pin level.
// - Input-only shared function leaves the port in full output control.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spio_port #(
  parameter logic [15:0] IMPL_MASK = 16'hffff,
  parameter logic [15:0] SHARED_MASK = 16'hffff
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [15:0] pad_in,
  input wire spio_pkg::spio_periph_t periph,
  output spio_pkg::spio_pad_t pad_out
);
  logic [15:0] direction;
  logic [15:0] latch;
  logic [15:0] periph_en;
  logic [15:0] level_meta;
  logic [15:0] level;
  logic [15:0] next_rdata;

  // Address decode
  wire logic hit_dir = addr == spio_pkg::OFF_DIRECTION;
  wire logic hit_lvl = addr == spio_pkg::OFF_LEVEL;
  wire logic hit_lat = addr == spio_pkg::OFF_LATCH;
  wire logic hit_pen = addr == spio_pkg::OFF_PERIPH_EN;
  wire logic hit_pout = addr == spio_pkg::OFF_PERIPH_OUT;

  // Either the latch or the level register address writes the latch
  wire logic latch_wr = wr && (hit_lat || hit_lvl);

  // Peripheral ownership: enabled, shared and actively driving
  wire logic [15:0] periph_owns = periph_en & SHARED_MASK & periph.drive;

  // Port output enable: output direction on implemented pins; peripheral ownership is applied in the pad mux
  wire logic [15:0] port_oe = ~direction & IMPL_MASK;

  // Pad muxes, peripheral first
  assign pad_out.data = (periph_owns & periph.data) | (~periph_owns & latch);
  assign pad_out.oe = periph_owns | (~periph_owns & port_oe);

  // Read mux; unimplemented bits masked to zero
  assign next_rdata = hit_dir ? (direction & IMPL_MASK) :
                      hit_lat ? (latch & IMPL_MASK) :
                      hit_lvl ? (level & IMPL_MASK) :
                      hit_pen ? (periph_en & IMPL_MASK) :
                      hit_pout ? (periph_owns & IMPL_MASK) :
                      spio_pkg::ZERO_WORD;

  // Control registers; direction forced to input on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      direction <= spio_pkg::DIR_RESET;
      latch <= spio_pkg::LATCH_RESET;
      periph_en <= spio_pkg::PEN_RESET;
    end else begin
      if (wr && hit_dir) direction <= wdata | ~IMPL_MASK;
      if (latch_wr) latch <= wdata & IMPL_MASK;
      if (wr && hit_pen) periph_en <= wdata & IMPL_MASK;
    end
  end

  // Two-stage synchroniser; only level is read by logic
  always_ff @(posedge clk) begin
    if (rst) begin
      level_meta <= spio_pkg::ZERO_WORD;
      level <= spio_pkg::ZERO_WORD;
    end else begin
      level_meta <= pad_in;
      level <= level_meta;
    end
  end

  // Read data registered, valid the cycle after rd
  always_ff @(posedge clk) begin
    if (rst) rdata <= spio_pkg::ZERO_WORD;
    else if (rd) rdata <= next_rdata;
    else rdata <= spio_pkg::ZERO_WORD;
  end

  // Assertions
  property p_dir_reset;
    @(posedge clk) $past(rst) |-> direction == spio_pkg::DIR_RESET;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not input after reset");
  property p_input_no_drive;
    @(posedge clk) disable iff (rst) (direction[0] == spio_pkg::DIR_INPUT && !periph_owns[0]) |-> !pad_out.oe[0];
  endproperty
  a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven");
  property p_latch_read;
    @(posedge clk) disable iff (rst) (rd && hit_lat) |=> rdata == (latch & IMPL_MASK);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong");
  property p_level_write;
    @(posedge clk) disable iff (rst) (wr && hit_lvl) |=> latch == ($past(wdata) & IMPL_MASK);
  endproperty
  a_level_write: assert property (p_level_write) else $error("level write missed latch");
  property p_level_read;
    @(posedge clk) disable iff (rst) (rd && hit_lvl) |=> rdata == ($past(pad_in, 3) & IMPL_MASK);
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read not synchronised pin");
  property p_port_data;
    @(posedge clk) disable iff (rst) (!periph_owns[0] && pad_out.oe[0]) |-> pad_out.data[0] == latch[0];
  endproperty
  a_port_data: assert property (p_port_data) else $error("port pin not from latch");
  property p_periph_wins;
    @(posedge clk) disable iff (rst) periph_owns[12] |-> (pad_out.oe[12] && pad_out.data[12] == periph.data[12]);
  endproperty
  a_periph_wins: assert property (p_periph_wins) else $error("peripheral lost pin");
  property p_idle_periph;
    @(posedge clk) disable iff (rst) (periph_en[0] && !periph.drive[0]) |-> pad_out.oe[0] == port_oe[0];
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("idle peripheral blocks port");
  property p_unimpl_zero;
    @(posedge clk) disable iff (rst) rd |=> (rdata & ~IMPL_MASK) == spio_pkg::ZERO_WORD;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read nonzero");
  property p_mux_split;
    @(posedge clk) disable iff (rst) !periph_owns[1] |-> pad_out.oe[1] == port_oe[1];
  endproperty
  a_mux_split: assert property (p_mux_split) else $error("port mux select wrong");
  property p_input_only;
    @(posedge clk) disable iff (rst) (periph_en & periph.drive & ~SHARED_MASK) != spio_pkg::ZERO_WORD |->
      ((pad_out.oe ^ port_oe) & ~SHARED_MASK) == spio_pkg::ZERO_WORD;
  endproperty
  a_input_only: assert property (p_input_only) else $error("dedicated pin overridden");
endmodule : spio_port
`default_nettype wire

// ===== verification/spio_pad_model.sv
// Pad cell model for the shared parallel I/O port
`timescale 1ns/10ps
`default_nettype none
module spio_pad_model (
  input wire spio_pkg::spio_pad_t pad_out,
  input wire logic [15:0] ext,
  output logic [15:0] pad_in
);
  // Driven pads show their data; released pads fall back to the board level, never the last value
  assign pad_in = (pad_out.oe & pad_out.data) | (~pad_out.oe & ext);
endmodule : spio_pad_model
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench for the shared parallel I/O port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rst, wr, rd;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, pad_in, ext;
  spio_pkg::spio_periph_t periph;
  spio_pkg::spio_pad_t pad_out;
  int fail_count = 0;
  int total_checks = 0;
  // Bit 15 left unimplemented and bit 14 dedicated, so the zero-read and dedicated-pin rules are exercised
  spio_port #(.IMPL_MASK(16'h7fff), .SHARED_MASK(16'hbfff)) i_dut (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pad_in(pad_in), .periph(periph), .pad_out(pad_out));
  spio_pad_model i_pads (.pad_out(pad_out), .ext(ext), .pad_in(pad_in));
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rd_chk
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // Main sequence; pads pass a synchroniser, so level reads wait three edges
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    periph = '0;
    ext = 16'h3c3c;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(spio_pkg::OFF_DIRECTION, 16'h7fff, "direction");
    chk("oe after reset", 16'h0000, pad_out.oe);
    rd_chk(spio_pkg::OFF_LEVEL, 16'h3c3c, "level inputs");
    wr_reg(spio_pkg::OFF_LATCH, 16'h00ff);
    rd_chk(spio_pkg::OFF_LATCH, 16'h00ff, "latch");
    wr_reg(spio_pkg::OFF_DIRECTION, 16'hff00);
    chk("oe", 16'h00ff, pad_out.oe);
    chk("pad data", 16'h00ff, pad_out.data);
    repeat (3) @(posedge clk);
    rd_chk(spio_pkg::OFF_LEVEL, 16'h3cff, "level mixed");
    wr_reg(spio_pkg::OFF_LEVEL, 16'h0055);
    rd_chk(spio_pkg::OFF_LATCH, 16'h0055, "latch via level");
    wr_reg(spio_pkg::OFF_PERIPH_EN, 16'hffff);
    chk("idle periph data", 16'h0055, pad_out.data);
    @(posedge clk);
    periph.drive <= 16'hf000;
    periph.data <= 16'ha000;
    #1;
    chk("owned oe", 16'h30ff, pad_out.oe);
    chk("owned data", 16'h2055, pad_out.data);
    repeat (3) @(posedge clk);
    rd_chk(spio_pkg::OFF_LEVEL, 16'h2c55, "level owned");
    rd_chk(spio_pkg::OFF_PERIPH_OUT, 16'h3000, "ownership");
    rd_chk(4'hf, 16'h0000, "unmapped");
    results();
  end
endmodule : tb_top
`default_nettype wire
